// ==== rtl/video_sync_trigger_qualifier.sv ====
// Purpose: video sync trigger qualifier with standard and custom video modes behind AHB-Lite
// Assumes: single-word AHB-Lite transfers, samples synchronous to ref_clk
// Notes:   zero-wait-state slave; read data registered in the address phase
//
// Functional notes
// - standard source is channel 1..2 (two-channel) or 1..4, or external.
// - external source accepted only on the two-channel variant.
// - standard source and polarity take effect only in 525 or 625 modes.
// - later standard settings and readbacks apply to the chosen source.
// - standard mode detects vertical sync with programmable polarity.
// - standard source readback returns the currently selected source.
// - custom mode arms only on a sync pulse of programmed polarity.
// - sync pulse arms only if longer than the minimum width.
// - minimum width spans 5 ns up to just under ten seconds.
// - after arming, count programmed horizontal sync events before edge search.
// - event delay count accepts 1 to 16,000,000.
// - after arming and delay, trigger fires on the selected edge.
// - custom trigger supports retrigger_a and noise_reject noise rejection.
// - event delay readback returns the last programmed value.
// - selected source compared against programmable level for pulses and edges.
`timescale 1ns/10ps
`default_nettype none
module video_sync_trigger_qualifier
	import video_trig_pkg::*;
#(
	parameter int NUM_CH   = 4,
	parameter int SAMPLE_W = 8
) (
	input  wire logic                           ref_clk,
	input  wire logic                           sys_rst,
	// ahb-lite slave
	input  wire logic                           hsel,
	input  wire logic [31:0]                    haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic                           hready,
	input  wire logic [31:0]                    hwdata,
	output logic [31:0]                         hrdata,
	output logic                                hreadyout,
	output logic                                hresp,
	// sampled waveforms
	input  wire logic [NUM_CH-1:0][SAMPLE_W-1:0] ch_sample,
	input  wire logic [SAMPLE_W-1:0]            ext_sample,
	// trigger results
	output logic                                trig_out,
	output logic                                vsync_det,
	output logic                                armed
);
	import video_trig_pkg::*;

	// refuse variants the source decode cannot serve
	if (NUM_CH < 1 || NUM_CH > 4) begin : g_ch_check
		$error("NUM_CH must be 1 to 4");
	end
	if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_w_check
		$error("SAMPLE_W must be 1 to 16");
	end

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ARM   = 5'b00010,
		ST_COUNT = 5'b00100,
		ST_EDGE  = 5'b01000,
		ST_HOLD  = 5'b10000
	} state_t;

	// configuration and state registers
	trig_mode_t          mode_q;
	standard_video_cfg_t std_q;
	custom_video_cfg_t   cust_q;
	cmp_cfg_t            cmp_q;
	logic [27:0]         min_sync_width_q;
	logic [23:0]         event_delay_count_q;
	logic [23:0]         retrigger_a_q;
	state_t              state_q;
	logic [27:0]         wcnt_q;
	logic [23:0]         ecnt_q;
	logic [23:0]         hold_q;
	logic [27:0]         vrun_q;
	logic                lvl_prev_q;
	logic [15:0]         trig_cnt_q;
	logic                rearm_q;

	// bus phase registers
	logic                dwr_q;
	logic [7:0]          daddr_q;
	logic [31:0]         rdata_q;

	logic                addr_ok;
	logic                wr_mode;
	logic                wr_std;
	logic                wr_cust;
	logic                wr_level;
	logic                wr_hyst;
	logic                wr_width;
	logic                wr_delay;
	logic                wr_hold;
	logic                std_active;
	logic [2:0]          sel_src;
	logic [SAMPLE_W-1:0] sel_sample;
	logic                lvl;
	logic                sync_act;
	logic                sync_lead;
	logic                edge_hit;
	logic                rearm_now;
	logic [31:0]         rd_mux;

	// checks a source code against this variant
	function automatic logic src_ok(input logic [2:0] s);
		logic ok;
		ok = 1'b0;
		if (s == SRC_EXT) ok = (NUM_CH == 2);
		else if (32'(s) <= NUM_CH) ok = 1'b1;
		return ok;
	endfunction : src_ok

	// saturate a width request into the legal span
	function automatic logic [27:0] clamp_width(input logic [31:0] v);
		logic [27:0] r;
		r = v[27:0];
		if (v < {4'h0, MIN_WIDTH_FLOOR_CYC}) r = MIN_WIDTH_FLOOR_CYC;
		else if (v > {4'h0, MIN_WIDTH_MAX_CYC}) r = MIN_WIDTH_MAX_CYC;
		return r;
	endfunction : clamp_width

	function automatic logic [23:0] clamp_delay(input logic [31:0] v);
		logic [23:0] r;
		r = v[23:0];
		if (v < {8'h00, EVENT_DELAY_MIN}) r = EVENT_DELAY_MIN;
		else if (v > {8'h00, EVENT_DELAY_MAX}) r = EVENT_DELAY_MAX;
		return r;
	endfunction : clamp_delay

	// slave never stalls and never errors
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;
	assign addr_ok   = hsel && htrans[1] && hready;

	// address phase: note write target, register read data now
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dwr_q   <= 1'b0;
			daddr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			dwr_q   <= addr_ok && hwrite && (hsize == 3'h2) && (haddr[1:0] == 2'h0);
			daddr_q <= haddr[7:0];
			if (addr_ok && !hwrite) rdata_q <= rd_mux;
		end
	end

	// data-phase write strobes
	always_comb begin
		wr_mode  = dwr_q && (daddr_q == OFS_MODE);
		wr_std   = dwr_q && (daddr_q == OFS_STD_CFG);
		wr_cust  = dwr_q && (daddr_q == OFS_CUST_CFG);
		wr_level = dwr_q && (daddr_q == OFS_LEVEL);
		wr_hyst  = dwr_q && (daddr_q == OFS_HYST);
		wr_width = dwr_q && (daddr_q == OFS_MIN_WIDTH);
		wr_delay = dwr_q && (daddr_q == OFS_EVENT_DELAY);
		wr_hold  = dwr_q && (daddr_q == OFS_RETRIGGER_A);
	end

	assign std_active = (mode_q == lines_525_standard) || (mode_q == lines_625_standard);

	// mode register, rearm request is a one-cycle strobe
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_q  <= MODE_OFF;
			rearm_q <= 1'b0;
		end else begin
			rearm_q <= wr_mode;
			if (wr_mode) mode_q <= trig_mode_t'(hwdata[MODE_LSB +: 2]);
		end
	end

	// standard settings accepted only while a standard mode runs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			std_q <= '{src: SRC_RESET, vertical_sync_polarity: 1'b0};
		end else if (wr_std && std_active) begin
			if (src_ok(hwdata[SRC_LSB +: 3])) std_q.src <= hwdata[SRC_LSB +: 3];
			std_q.vertical_sync_polarity <= hwdata[POL_BIT];
		end
	end

	// custom settings; bad source codes keep the old choice
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cust_q <= '{src: SRC_RESET, sync_polarity: 1'b0, edge_falling: 1'b0};
		end else if (wr_cust) begin
			if (src_ok(hwdata[SRC_LSB +: 3])) cust_q.src <= hwdata[SRC_LSB +: 3];
			cust_q.sync_polarity <= hwdata[POL_BIT];
			cust_q.edge_falling  <= hwdata[EDGE_BIT];
		end
	end

	// level, band, width, delay and retrigger_a settings
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cmp_q               <= '{level: LEVEL_RESET, noise_reject: HYST_RESET};
			min_sync_width_q    <= MIN_WIDTH_FLOOR_CYC;
			event_delay_count_q <= EVENT_DELAY_MIN;
			retrigger_a_q       <= RETRIGGER_A_RESET;
		end else begin
			if (wr_level) cmp_q.level <= hwdata[15:0];
			if (wr_hyst) cmp_q.noise_reject <= hwdata[15:0];
			if (wr_width) min_sync_width_q <= clamp_width(hwdata);
			if (wr_delay) event_delay_count_q <= clamp_delay(hwdata);
			if (wr_hold) retrigger_a_q <= hwdata[23:0];
		end
	end

	// readback; unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			OFS_MODE:        rd_mux[MODE_LSB +: 2] = mode_q;
			OFS_STD_CFG: begin
				rd_mux[SRC_LSB +: 3] = std_q.src;
				rd_mux[POL_BIT]      = std_q.vertical_sync_polarity;
			end
			OFS_CUST_CFG: begin
				rd_mux[SRC_LSB +: 3] = cust_q.src;
				rd_mux[POL_BIT]      = cust_q.sync_polarity;
				rd_mux[EDGE_BIT]     = cust_q.edge_falling;
			end
			OFS_LEVEL:       rd_mux[15:0] = cmp_q.level;
			OFS_HYST:        rd_mux[15:0] = cmp_q.noise_reject;
			OFS_MIN_WIDTH:   rd_mux[27:0] = min_sync_width_q;
			OFS_EVENT_DELAY: rd_mux[23:0] = event_delay_count_q;
			OFS_RETRIGGER_A:     rd_mux[23:0] = retrigger_a_q;
			OFS_STATUS: begin
				rd_mux[ST_STATE_LSB +: 5]  = state_q;
				rd_mux[ST_LEVEL_BIT]       = lvl;
				rd_mux[ST_COUNT_LSB +: 16] = trig_cnt_q;
			end
			default:         rd_mux = 32'h00000000;
		endcase
	end

	// source select: standard modes use their own chosen source
	assign sel_src = std_active ? std_q.src : cust_q.src;

	always_comb begin
		sel_sample = ext_sample;
		for (int i = 0; i < NUM_CH; i++) begin
			if (32'(sel_src) == i + 1) sel_sample = ch_sample[i];
		end
	end

	// single comparator on the selected source
	level_comparator #(
		.SAMPLE_W (SAMPLE_W)
	) u_cmp (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.sample  (sel_sample),
		.cfg     (cmp_q),
		.above   (lvl)
	);

	// sync is active when the level matches the chosen polarity
	always_comb begin
		sync_act  = std_active ? (lvl == std_q.vertical_sync_polarity) : (lvl == cust_q.sync_polarity);
		sync_lead = sync_act && (lvl != lvl_prev_q);
		edge_hit  = (lvl != lvl_prev_q) && (lvl == !cust_q.edge_falling);
		rearm_now = rearm_q || (mode_q != custom_video);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) lvl_prev_q <= 1'b0;
		else lvl_prev_q <= lvl;
	end

	// standard mode: vertical sync is a long pulse of the chosen polarity
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vrun_q    <= 28'h0000000;
			vsync_det <= 1'b0;
		end else begin
			vsync_det <= 1'b0;
			if (!std_active || !sync_act) begin
				vrun_q <= 28'h0000000;
			end else if (vrun_q != VSYNC_MIN_CYC) begin
				vrun_q <= vrun_q + 28'h0000001;
				if (vrun_q == VSYNC_MIN_CYC - 28'h0000001) vsync_det <= 1'b1;
			end
		end
	end

	// custom sequence: arm on wide sync, count syncs, fire on edge, hold off
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			wcnt_q  <= 28'h0000000;
			ecnt_q  <= 24'h000000;
			hold_q  <= 24'h000000;
		end else if (rearm_now) begin
			// fresh measurement each sequence, also on mode change
			state_q <= (mode_q == custom_video) ? ST_ARM : ST_IDLE;
			wcnt_q  <= 28'h0000000;
			ecnt_q  <= 24'h000000;
			hold_q  <= 24'h000000;
		end else begin
			case (state_q)
				ST_IDLE: begin
					state_q <= ST_ARM;
				end
				ST_ARM: begin
					if (!sync_act) begin
						wcnt_q <= 28'h0000000;
					end else if (wcnt_q >= min_sync_width_q) begin
						// this cycle makes the pulse longer than the minimum
						state_q <= ST_COUNT;
						ecnt_q  <= 24'h000000;
					end else begin
						wcnt_q <= wcnt_q + 28'h0000001;
					end
				end
				ST_COUNT: begin
					if (sync_lead) begin
						ecnt_q <= ecnt_q + 24'h000001;
						if (ecnt_q + 24'h000001 >= event_delay_count_q) state_q <= ST_EDGE;
					end
				end
				ST_EDGE: begin
					if (edge_hit) begin
						wcnt_q  <= 28'h0000000;
						ecnt_q  <= 24'h000000;
						hold_q  <= retrigger_a_q;
						state_q <= (retrigger_a_q == 24'h000000) ? ST_ARM : ST_HOLD;
					end
				end
				ST_HOLD: begin
					// retrigger_a keeps the next sequence from starting too soon
					if (hold_q <= 24'h000001) state_q <= ST_ARM;
					hold_q <= hold_q - 24'h000001;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// trigger pulse: custom edge or standard vertical sync
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			trig_out   <= 1'b0;
			trig_cnt_q <= 16'h0000;
		end else begin
			trig_out <= 1'b0;
			if ((!rearm_now && state_q == ST_EDGE && edge_hit) || vsync_det) begin
				trig_out   <= 1'b1;
				trig_cnt_q <= trig_cnt_q + 16'h0001;
			end
		end
	end

	// armed covers the delay count and the edge search
	always_ff @(posedge ref_clk) begin
		if (sys_rst) armed <= 1'b0;
		else armed <= !rearm_now && (state_q == ST_COUNT || state_q == ST_EDGE ||
			(state_q == ST_ARM && sync_act && wcnt_q >= min_sync_width_q));
	end

endmodule : video_sync_trigger_qualifier
`default_nettype wire

// ==== rtl/video_trig_pkg.sv ====
// Purpose: shared constants and carrier types for the video sync trigger qualifier
// Assumes: 20 MHz ref_clk, 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   register values are held in cycles of ref_clk unless stated otherwise
package video_trig_pkg;

	// clock rate and timing
	localparam longint CLK_HZ             = 64'd20000000;
	localparam longint MIN_WIDTH_FLOOR_PS = 64'd5000;            // 5 ns lower bound
	localparam longint MIN_WIDTH_MAX_PS   = 64'd9999999990000;   // 9.99999999 s upper bound
	localparam longint VSYNC_MIN_NS       = 64'd10000;           // standard-mode vertical sync qualifier
	// least time rounds up, longest time rounds down, never below one cycle
	localparam longint FLOOR_RAW = (MIN_WIDTH_FLOOR_PS * CLK_HZ + 64'd999999999999) / 64'd1000000000000;
	localparam logic [27:0] MIN_WIDTH_FLOOR_CYC = 28'((FLOOR_RAW < 64'd1) ? 64'd1 : FLOOR_RAW);
	localparam logic [27:0] MIN_WIDTH_MAX_CYC   = 28'((MIN_WIDTH_MAX_PS / 64'd1000) * CLK_HZ / 64'd1000000000);
	localparam logic [27:0] VSYNC_MIN_CYC       = 28'((VSYNC_MIN_NS * CLK_HZ + 64'd999999999) / 64'd1000000000);

	// event delay range
	localparam logic [23:0] EVENT_DELAY_MIN = 24'h000001;
	localparam logic [23:0] EVENT_DELAY_MAX = 24'hF42400;        // 16,000,000

	// register byte offsets
	localparam logic [7:0] OFS_MODE        = 8'h00;
	localparam logic [7:0] OFS_STD_CFG     = 8'h04;
	localparam logic [7:0] OFS_CUST_CFG    = 8'h08;
	localparam logic [7:0] OFS_LEVEL       = 8'h0C;
	localparam logic [7:0] OFS_HYST        = 8'h10;
	localparam logic [7:0] OFS_MIN_WIDTH   = 8'h14;
	localparam logic [7:0] OFS_EVENT_DELAY = 8'h18;
	localparam logic [7:0] OFS_RETRIGGER_A     = 8'h1C;
	localparam logic [7:0] OFS_STATUS      = 8'h20;

	// field positions
	localparam int MODE_LSB    = 0;
	localparam int REARM_BIT   = 8;
	localparam int SRC_LSB     = 0;
	localparam int POL_BIT     = 4;
	localparam int EDGE_BIT    = 5;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_LEVEL_BIT = 8;
	localparam int ST_COUNT_LSB = 16;

	// source codes: 0 is the external input, 1..N the channels
	localparam logic [2:0] SRC_EXT   = 3'h0;
	localparam logic [2:0] SRC_RESET = 3'h1;

	// trigger modes
	typedef enum logic [1:0] {
		MODE_OFF           = 2'h0,
		lines_525_standard = 2'h1,
		lines_625_standard = 2'h2,
		custom_video       = 2'h3
	} trig_mode_t;

	// reset values
	localparam logic [15:0] LEVEL_RESET   = 16'h0080;
	localparam logic [15:0] HYST_RESET    = 16'h0000;
	localparam logic [23:0] RETRIGGER_A_RESET = 24'h000000;

	// comparator settings travel together
	typedef struct packed {
		logic [15:0] level;
		logic [15:0] noise_reject;
	} cmp_cfg_t;

	typedef struct packed {
		logic [2:0] src;
		logic       vertical_sync_polarity;   // 1 positive-going, 0 negative-going
	} standard_video_cfg_t;

	typedef struct packed {
		logic [2:0] src;
		logic       sync_polarity;            // 1 positive pulse arms
		logic       edge_falling;             // 1 falling edge fires
	} custom_video_cfg_t;

endpackage : video_trig_pkg

// ==== rtl/level_comparator.sv ====
// Purpose: compares one sample stream against the trigger level with a noise_reject band
// Assumes: unsigned samples synchronous to ref_clk
// Notes:   output is registered; band is symmetric about the level
`timescale 1ns/10ps
`default_nettype none
module level_comparator
	import video_trig_pkg::*;
#(
	parameter int SAMPLE_W = 8
) (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire logic [SAMPLE_W-1:0]           sample,
	input  wire video_trig_pkg::cmp_cfg_t      cfg,
	output logic                               above
);
	import video_trig_pkg::*;

	logic [SAMPLE_W+1:0] samp_w;
	logic [SAMPLE_W+1:0] hi_thr;
	logic [SAMPLE_W+1:0] lo_thr;
	logic [SAMPLE_W+1:0] lvl_w;
	logic [SAMPLE_W+1:0] hys_w;

	// widen before adding so the band never wraps
	always_comb begin
		samp_w = {2'b00, sample};
		lvl_w  = {2'b00, cfg.level[SAMPLE_W-1:0]};
		hys_w  = {2'b00, cfg.noise_reject[SAMPLE_W-1:0]};
		hi_thr = lvl_w + hys_w;
		lo_thr = (lvl_w > hys_w) ? (lvl_w - hys_w) : '0;
	end

	// rises above level+band, falls below level-band
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			above <= 1'b0;
		end else if (above) begin
			if (samp_w < lo_thr) above <= 1'b0;
		end else begin
			if (samp_w > hi_thr) above <= 1'b1;
		end
	end

endmodule : level_comparator
`default_nettype wire

// ==== test/video_wave_source.sv ====
// Purpose: far-side model, one sampled video waveform
// Assumes: samples change just after a ref_clk edge
// Notes:   only two levels, well clear of the 0x80 level
`timescale 1ns/10ps
`default_nettype none
module video_wave_source (
	input  wire logic       ref_clk,
	output logic [7:0]      sample
);
	initial sample = 8'h40;
	// hold one level for n cycles; levels straddle the trigger level
	task automatic drive(input logic act, input int n);
		sample <= act ? 8'hC0 : 8'h40;
		repeat (n) @(posedge ref_clk);
	endtask : drive
endmodule : video_wave_source
`default_nettype wire

// ==== test/video_sync_trigger_qualifier_monitor.sv ====
// Purpose: port-level checks of the video sync trigger qualifier
// Assumes: one ref_clk domain, sys_rst synchronous active high
// Notes:   watches outputs and the bus request inputs; bound from the testbench top
`timescale 1ns/10ps
`default_nettype none
module video_sync_trigger_qualifier_monitor (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic        trig_out,
	input  wire logic        vsync_det,
	input  wire logic        armed
);
	logic rd_take;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// read address phase accepted at this edge
	assign rd_take = hsel && htrans[1] && hready && !hwrite;
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_trig_single: assert property (trig_out |=> !trig_out)
		else $error("trig_out longer than one cycle");
	a_vsync_single: assert property (vsync_det |=> !vsync_det)
		else $error("vsync_det longer than one cycle");
	a_vsync_trig: assert property (vsync_det |=> trig_out)
		else $error("no trigger after vertical sync");
	a_quiet_reset: assert property ($past(sys_rst) |-> !armed && !trig_out && !vsync_det)
		else $error("outputs active after reset");
	a_trig_armed: assert property (trig_out && !$past(vsync_det) |-> $past(armed))
		else $error("custom trigger while not armed");
	a_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
		else $error("hrdata moved without a read");
endmodule : video_sync_trigger_qualifier_monitor
`default_nettype wire

// ==== test/video_sync_trigger_qualifier_tb.sv ====
// Purpose: self-checking bench of the video sync trigger qualifier
// Assumes: default NUM_CH 4, so the external source is refused
// Notes:   hready loops back from hreadyout, single slave
`timescale 1ns/10ps
`default_nettype none
module video_sync_trigger_qualifier_tb;
	import video_trig_pkg::*;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic [1:0]  htrans  = 2'h0;
	logic [2:0]  hsize   = 3'h2;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        trig_out;
	logic        vsync_det;
	logic        armed;
	logic [7:0]  wave;
	int          mismatches = 0;
	int          compares = 0;
	int          trig_n = 0;
	int          vs_n = 0;
	always #25 ref_clk = ~ref_clk;
	video_wave_source src_u (.ref_clk(ref_clk), .sample(wave));
	video_sync_trigger_qualifier dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ch_sample({{3{8'h40}}, wave}), .ext_sample(8'h40),
		.trig_out(trig_out), .vsync_det(vsync_det), .armed(armed));
	// pulse counters, so no one-cycle pulse is missed
	always @(posedge ref_clk) begin
		trig_n += int'(trig_out === 1'b1);
		vs_n += int'(vsync_det === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask : rc
	task automatic t_reset();
		rc(OFS_MODE, 32'h0);
		rc(OFS_STD_CFG, 32'h1);
		rc(OFS_CUST_CFG, 32'h1);
		rc(OFS_LEVEL, 32'h80);
		rc(OFS_HYST, 32'h0);
		rc(OFS_MIN_WIDTH, 32'h1);
		rc(OFS_EVENT_DELAY, 32'h1);
		rc(OFS_RETRIGGER_A, 32'h0);
		rc(OFS_STATUS, 32'h1);
		rc(8'h24, 32'h0);
	endtask : t_reset
	// limits of the two counts, readback of the last value
	task automatic t_limits();
		wr(OFS_EVENT_DELAY, 32'h5);
		rc(OFS_EVENT_DELAY, 32'h5);
		wr(OFS_EVENT_DELAY, 32'h0);
		rc(OFS_EVENT_DELAY, 32'h1);
		wr(OFS_EVENT_DELAY, 32'hF42401);
		rc(OFS_EVENT_DELAY, 32'hF42400);
		wr(OFS_MIN_WIDTH, 32'h0);
		rc(OFS_MIN_WIDTH, 32'h1);
		wr(OFS_MIN_WIDTH, 32'hFFFFFFF);
		rc(OFS_MIN_WIDTH, 32'hBEBC1FF);
	endtask : t_limits
	task automatic t_std();
		int v;
		int t;
		wr(OFS_STD_CFG, 32'h13);
		rc(OFS_STD_CFG, 32'h1);
		wr(OFS_MODE, 32'h1);
		wr(OFS_STD_CFG, 32'h10);
		rc(OFS_STD_CFG, 32'h11);
		wr(OFS_STD_CFG, 32'h3);
		rc(OFS_STD_CFG, 32'h3);
		wr(OFS_STD_CFG, 32'h5);
		rc(OFS_STD_CFG, 32'h3);
		// both polarities, one in each line-count mode
		for (int p = 0; p < 2; p++) begin
			src_u.drive(!p, 5);
			wr(OFS_MODE, p ? 32'h2 : 32'h1);
			wr(OFS_STD_CFG, p ? 32'h11 : 32'h1);
			v = vs_n;
			t = trig_n;
			src_u.drive(p, 210);
			src_u.drive(!p, 5);
			chk(32'(vs_n - v), 32'h1);
			chk(32'(trig_n - t), 32'h1);
		end
	endtask : t_std
	task automatic t_cust();
		int t;
		wr(OFS_MODE, 32'h3);
		// positive sync first, so the idle low level cannot arm
		wr(OFS_CUST_CFG, 32'h11);
		wr(OFS_MIN_WIDTH, 32'h4);
		wr(OFS_EVENT_DELAY, 32'h2);
		src_u.drive(1'b0, 20);
		chk({31'h0, armed}, 32'h0);
		src_u.drive(1'b1, 4);
		src_u.drive(1'b0, 3);
		chk({31'h0, armed}, 32'h0);
		for (int e = 0; e < 2; e++) begin
			wr(OFS_CUST_CFG, e ? 32'h31 : 32'h11);
			wr(OFS_MODE, 32'h3);
			t = trig_n;
			src_u.drive(1'b1, 8);
			chk({31'h0, armed}, 32'h1);
			src_u.drive(1'b0, 3);
			src_u.drive(1'b1, 3);
			chk(32'(trig_n - t), 32'h0);
			src_u.drive(1'b0, 3);
			src_u.drive(1'b1, 3);
			src_u.drive(1'b0, 3);
			src_u.drive(1'b1, 1);
			src_u.drive(1'b0, 4);
			chk(32'(trig_n - t), 32'h1);
		end
	endtask : t_cust
	task automatic t_rearm();
		logic [31:0] x;
		src_u.drive(1'b1, 8);
		chk({31'h0, armed}, 32'h1);
		wr(OFS_MODE, 32'h3);
		src_u.drive(1'b0, 3);
		chk({31'h0, armed}, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0, x);
		chk({26'h0, x[8], x[4:0]}, 32'h2);
		wr(OFS_LEVEL, 32'hD0);
		src_u.drive(1'b1, 8);
		chk({31'h0, armed}, 32'h0);
		wr(OFS_LEVEL, 32'h80);
	endtask : t_rearm
	// retrigger_a keeps the next sequence off; the band hides a small crossing
	task automatic t_cond();
		logic [31:0] x;
		int t;
		wr(OFS_EVENT_DELAY, 32'h1);
		wr(OFS_RETRIGGER_A, 32'h28);
		src_u.drive(1'b0, 3);
		wr(OFS_MODE, 32'h3);
		t = trig_n;
		src_u.drive(1'b1, 8);
		src_u.drive(1'b0, 3);
		src_u.drive(1'b1, 3);
		src_u.drive(1'b0, 4);
		chk(32'(trig_n - t), 32'h1);
		// a wide pulse inside the retrigger_a must not arm
		src_u.drive(1'b1, 8);
		chk({31'h0, armed}, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0, x);
		chk({27'h0, x[4:0]}, 32'h10);
		chk({16'h0, x[31:16]}, 32'h5);
		src_u.drive(1'b0, 40);
		src_u.drive(1'b1, 8);
		chk({31'h0, armed}, 32'h1);
		// band of 0x50 lifts the rising threshold above the high level
		src_u.drive(1'b0, 3);
		wr(OFS_HYST, 32'h50);
		wr(OFS_MODE, 32'h3);
		src_u.drive(1'b1, 8);
		chk({31'h0, armed}, 32'h0);
	endtask : t_cond
	task automatic final_report();
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		hsel <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_limits();
		t_std();
		t_cust();
		t_rearm();
		t_cond();
		final_report();
	end
	// run takes about 740 cycles; generous cut-off
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		final_report();
	end
endmodule : video_sync_trigger_qualifier_tb
bind video_sync_trigger_qualifier video_sync_trigger_qualifier_monitor mon_u (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .trig_out(trig_out), .vsync_det(vsync_det), .armed(armed));
`default_nettype wire
